// ### core/ciu_exception_unit.sv
/*
 * exception unit of the core: interrupt recognition, acknowledge cycle,
 * traps, illegal/unimplemented opcodes, privilege violations.
 * assumes the sequencer pulses i_boundary between instructions and holds
 * decoded opcode/condition inputs valid during that pulse; stack writes
 * and vector fetch complete on a one-cycle i_mem_done.
 */
// Notes on behaviour
// - seven levels, 3-bit mask, mask blocks lower-equal
// - active-low lines; all negated means idle
// - requests pend; examined only at instruction boundary
// - level not above mask: continue, stay deferred
// - accept: copy status, supervisor, no trace, mask
// - acknowledge cycle shows level on address bus
// - autovector request yields level-based vector number
// - push counter of next unexecuted instruction, status
// - level seven is nonmaskable, even mask seven
// - seven edge-detected, lower levels level-sensitive
// - lowered mask re-recognises held seven, restores seven
// - bus fault in acknowledge gives spurious vector
// - trap: copy status, supervisor, field-based vector
// - traps: system call, failed checks, zero divide
// - illegal opcodes and reserved patterns trap
// - two line patterns get own vectors
// - illegal: short frame then illegal vector
// - user-mode privileged opcode: privilege violation
// - finally load counter from vector, resume
`timescale 1ns/1ns
module ciu_exception_unit
    import ciu_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // interrupt request pins
    input  wire logic [2:0]  i_priority_request_lines_n,
    // sequencer
    input  wire logic        i_boundary,
    input  wire logic [15:0] i_opcode,
    input  wire logic        i_opcode_legal,
    input  wire logic        i_opcode_privileged,
    input  wire logic        i_overflow_check_fail,
    input  wire logic        i_bound_check_fail,
    input  wire logic        i_divide_by_zero,
    input  wire logic [31:0] i_next_pc,
    input  wire logic [15:0] i_status,
    // acknowledge cycle responses
    input  wire logic        i_transfer_ack_n,
    input  wire logic        i_autovector_request_n,
    input  wire logic        i_bus_fault_n,
    input  wire logic [7:0]  i_ack_data,
    // memory side
    input  wire logic        i_mem_done,
    // outputs
    output logic             o_busy,
    output logic             o_ack_cycle,
    output logic [2:0]       o_ack_level,
    output logic             o_push_pc,
    output logic             o_push_sr,
    output logic [31:0]      o_stack_pc,
    output logic [15:0]      o_stack_sr,
    output logic             o_vector_fetch,
    output logic [7:0]       o_vector,
    output logic             o_short_frame,
    output logic [15:0]      o_status
);

    // ==========================================================
    // decode helpers
    // ==========================================================
    function automatic logic is_reserved(input logic [15:0] op);
        return op == OP_RSV_A || op == OP_RSV_B || op == OP_RSV_C;
    endfunction : is_reserved

    function automatic logic is_syscall(input logic [15:0] op);
        return op[15:4] == SYSCALL_HI;
    endfunction : is_syscall

    // the top nibble of the word names its opcode line
    function automatic logic is_line(input logic [15:0] op,
                                     input logic [3:0]  pat);
        return op[15:12] == pat;
    endfunction : is_line

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  lvl_prev;
        logic        nmi_pend;
        ciu_state_t  st;
        logic [2:0]  ack_lvl;
        logic [31:0] pc;
        logic [15:0] sr_copy;
        logic [15:0] sr;
        logic [7:0]  vec;
        logic        short_frame;
    } ciu_regs_t;

    ciu_regs_t r_q;
    ciu_regs_t r_d;

    logic [2:0] req_lvl;
    logic [2:0] mask;
    logic       int_take;
    logic       exc_take;
    logic [7:0] exc_vec;

    assign req_lvl = ~r_q.sync2;
    assign mask    = i_status[SR_MASK_HI:SR_MASK_LO];

    always_comb begin
        // priority among instruction-caused exceptions
        exc_take = 1'b1;
        exc_vec  = VEC_ILLEGAL;
        if (i_opcode[15:12] == LINE_A_PAT) begin
            exc_vec = VEC_LINE_A;
        end else if (i_opcode[15:12] == LINE_F_PAT) begin
            exc_vec = VEC_LINE_F;
        end else if (is_reserved(i_opcode) || !i_opcode_legal) begin
            exc_vec = VEC_ILLEGAL;
        end else if (i_opcode_privileged && !i_status[SR_S_BIT]) begin
            exc_vec = VEC_PRIV;
        end else if (is_syscall(i_opcode)) begin
            // the low nibble alone picks one of sixteen call vectors
            exc_vec = VEC_SYSCALL_BASE + 8'(i_opcode[3:0]);
        end else if (i_overflow_check_fail) begin
            exc_vec = VEC_OVERFLOW;
        end else if (i_bound_check_fail) begin
            exc_vec = VEC_BOUND;
        end else if (i_divide_by_zero) begin
            exc_vec = VEC_ZERO_DIV;
        end else begin
            exc_take = 1'b0;
        end
    end

    // seven by latched edge or lowered mask; others by level
    assign int_take = (req_lvl == LVL_NMI)
                    ? (r_q.nmi_pend || mask != LVL_NMI)
                    : (req_lvl != LVL_NONE && req_lvl > mask);

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        r_d          = r_q;
        r_d.sync1    = i_priority_request_lines_n;
        r_d.sync2    = r_q.sync1;
        r_d.lvl_prev = req_lvl;
        if (req_lvl == LVL_NMI && r_q.lvl_prev != LVL_NMI) begin
            r_d.nmi_pend = 1'b1;
        end
        unique case (r_q.st)
            CIU_RUN: begin
                r_d.sr = i_status;
                if (i_boundary && (int_take || exc_take)) begin
                    r_d.sr_copy = i_status;
                    r_d.sr[SR_S_BIT] = 1'b1;
                    r_d.sr[SR_T_BIT] = 1'b0;
                    r_d.pc = i_next_pc;
                    r_d.short_frame = 1'b1;
                    if (int_take) begin
                        r_d.ack_lvl = req_lvl;
                        // an accepted seven uses up its own edge only
                        if (req_lvl == LVL_NMI) begin
                            r_d.nmi_pend = 1'b0;
                        end
                        r_d.sr[SR_MASK_HI:SR_MASK_LO] = req_lvl;
                        r_d.st = CIU_ACK;
                    end else begin
                        // trap counter points past the opcode
                        r_d.pc = i_next_pc;
                        r_d.vec = exc_vec;
                        r_d.st = CIU_PUSH_PC;
                    end
                end
            end
            CIU_ACK: begin
                if (!i_autovector_request_n) begin
                    r_d.vec = VEC_AUTO_BASE + {5'h00, r_q.ack_lvl};
                    r_d.st  = CIU_PUSH_PC;
                end else if (!i_transfer_ack_n) begin
                    r_d.vec = i_ack_data;
                    r_d.st  = CIU_PUSH_PC;
                end else if (!i_bus_fault_n) begin
                    r_d.vec = VEC_SPURIOUS;
                    r_d.st  = CIU_PUSH_PC;
                end
            end
            CIU_PUSH_PC: begin
                if (i_mem_done) begin
                    r_d.st = CIU_PUSH_SR;
                end
            end
            CIU_PUSH_SR: begin
                if (i_mem_done) begin
                    r_d.st = CIU_FETCH;
                end
            end
            CIU_FETCH: begin
                if (i_mem_done) begin
                    r_d.st = CIU_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r_q <= '{sync1: LINES_IDLE, sync2: LINES_IDLE,
                     lvl_prev: LVL_NONE, st: CIU_RUN, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign o_busy         = r_q.st != CIU_RUN;
    assign o_ack_cycle    = r_q.st == CIU_ACK;
    assign o_ack_level    = r_q.ack_lvl;
    assign o_push_pc      = r_q.st == CIU_PUSH_PC;
    assign o_push_sr      = r_q.st == CIU_PUSH_SR;
    assign o_stack_pc     = r_q.pc;
    assign o_stack_sr     = r_q.sr_copy;
    assign o_vector_fetch = r_q.st == CIU_FETCH;
    assign o_vector       = r_q.vec;
    assign o_short_frame  = r_q.short_frame;
    assign o_status       = r_q.sr;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_mask_loaded: assert property (
        r_q.st == CIU_RUN ##1 r_q.st == CIU_ACK |->
        r_q.sr[SR_MASK_HI:SR_MASK_LO] == r_q.ack_lvl
        && r_q.sr[SR_S_BIT] && !r_q.sr[SR_T_BIT])
        else $error("mask or mode not set on interrupt accept");
    a_no_early_take: assert property (
        r_q.st == CIU_RUN && !i_boundary |=> r_q.st == CIU_RUN)
        else $error("exception started off a boundary");
    a_deferred_int: assert property (
        r_q.st == CIU_RUN && i_boundary && !exc_take && req_lvl != LVL_NMI
        && req_lvl <= mask |=> r_q.st == CIU_RUN)
        else $error("masked interrupt was taken");
    a_nmi_take: assert property (
        r_q.st == CIU_RUN && i_boundary && r_q.nmi_pend
        && req_lvl == LVL_NMI |=> r_q.st == CIU_ACK)
        else $error("level seven edge not taken");
    a_nmi_consume: assert property (
        r_q.st == CIU_RUN && i_boundary && int_take
        && req_lvl == LVL_NMI |=> !r_q.nmi_pend)
        else $error("held seven recognised twice");
    a_ack_level: assert property (
        o_ack_cycle |-> o_ack_level != LVL_NONE
        && o_ack_level == o_status[SR_MASK_HI:SR_MASK_LO])
        else $error("ack level missing");
    a_autovec: assert property (
        o_ack_cycle && !i_autovector_request_n |=>
        o_vector == VEC_AUTO_BASE + {5'h00, r_q.ack_lvl})
        else $error("wrong autovector");
    a_spurious: assert property (
        o_ack_cycle && i_autovector_request_n && i_transfer_ack_n
        && !i_bus_fault_n |=> o_vector == VEC_SPURIOUS && o_push_pc)
        else $error("spurious vector not used");
    a_illegal_vec: assert property (
        r_q.st == CIU_RUN && i_boundary && !int_take
        && i_opcode == OP_RSV_C |=> o_vector == VEC_ILLEGAL)
        else $error("reserved pattern not illegal");
    a_frame_order: assert property (
        o_push_sr && i_mem_done |=> o_vector_fetch)
        else $error("vector fetch not after stacking");

    // ==========================================================
    // interrupt entry checks
    // ==========================================================
    a_nmi_latched: assert property (
        req_lvl == LVL_NMI && r_q.lvl_prev != LVL_NMI
        && !(r_q.st == CIU_RUN && i_boundary && int_take) |=> r_q.nmi_pend)
        else $error("level seven edge not latched");
    a_ack_start: assert property (
        r_q.st == CIU_RUN && i_boundary && int_take |=>
        o_ack_cycle && o_ack_level == $past(req_lvl))
        else $error("acknowledge cycle not started");
    a_ack_hold: assert property (
        o_ack_cycle && i_autovector_request_n && i_transfer_ack_n
        && i_bus_fault_n |=> o_ack_cycle && $stable(o_ack_level))
        else $error("acknowledge cycle ended without answer");
    a_ack_vector: assert property (
        o_ack_cycle && i_autovector_request_n && !i_transfer_ack_n |=>
        o_vector == $past(i_ack_data) && o_push_pc)
        else $error("supplied vector not taken");

    // ==========================================================
    // exception and stacking checks
    // ==========================================================
    a_stack_copy: assert property (
        r_q.st == CIU_RUN && i_boundary && (int_take || exc_take) |=>
        o_stack_pc == $past(i_next_pc) && o_stack_sr == $past(i_status))
        else $error("stacked counter or status wrong");
    a_trap_mode: assert property (
        r_q.st == CIU_RUN && i_boundary && !int_take && exc_take |=>
        o_push_pc && o_status[SR_S_BIT] && !o_status[SR_T_BIT]
        && o_status[SR_MASK_HI:SR_MASK_LO] == $past(mask))
        else $error("trap entry status wrong");
    a_priv_vec: assert property (
        r_q.st == CIU_RUN && i_boundary && !int_take && i_opcode_legal
        && i_opcode_privileged && !i_status[SR_S_BIT]
        && !is_line(i_opcode, LINE_A_PAT) && !is_line(i_opcode, LINE_F_PAT)
        && !is_reserved(i_opcode) |=> o_vector == VEC_PRIV)
        else $error("privilege violation vector wrong");
    a_line_vec: assert property (
        r_q.st == CIU_RUN && i_boundary && !int_take
        && is_line(i_opcode, LINE_F_PAT) |=> o_vector == VEC_LINE_F)
        else $error("unimplemented line vector wrong");
    a_push_order: assert property (
        o_push_pc && i_mem_done |=> o_push_sr)
        else $error("status push not after counter push");
    a_fetch_resume: assert property (
        o_vector_fetch && i_mem_done |=> !o_busy)
        else $error("no resume after vector fetch");
    a_busy_hold: assert property (
        o_busy && !o_ack_cycle && !i_mem_done |=>
        $stable(o_vector) && $stable(o_stack_pc) && o_busy)
        else $error("stacking step dropped early");

    // main scenarios reached
    c_interrupt: cover property (o_ack_cycle ##1 o_push_pc);
    c_autovec: cover property (o_ack_cycle && !i_autovector_request_n);
    c_trap: cover property (o_push_pc && o_vector >= VEC_SYSCALL_BASE);
    c_nmi: cover property (o_ack_cycle && o_ack_level == LVL_NMI);
    c_spurious: cover property (o_ack_cycle && !i_bus_fault_n
        && i_autovector_request_n && i_transfer_ack_n);

endmodule : ciu_exception_unit

// ### core/ciu_pkg.sv
/*
 * constants, vectors and state types for the core exception unit.
 * assumes a 16-bit opcode word, 32-bit counter and 16-bit status word.
 */
package ciu_pkg;

    // status word field positions
    localparam int SR_T_BIT      = 15;
    localparam int SR_S_BIT      = 13;
    localparam int SR_MASK_LO    = 8;
    localparam int SR_MASK_HI    = 10;

    localparam logic [2:0]  LVL_NONE = 3'h0;
    localparam logic [2:0]  LVL_NMI  = 3'h7;
    localparam logic [2:0]  LINES_IDLE = 3'h7;

    // exception vector numbers
    localparam logic [7:0]  VEC_ILLEGAL   = 8'h04;
    localparam logic [7:0]  VEC_ZERO_DIV  = 8'h05;
    localparam logic [7:0]  VEC_BOUND     = 8'h06;
    localparam logic [7:0]  VEC_OVERFLOW  = 8'h07;
    localparam logic [7:0]  VEC_PRIV      = 8'h08;
    localparam logic [7:0]  VEC_LINE_A    = 8'h0A;
    localparam logic [7:0]  VEC_LINE_F    = 8'h0B;
    localparam logic [7:0]  VEC_SPURIOUS  = 8'h18;
    localparam logic [7:0]  VEC_AUTO_BASE = 8'h18;
    localparam logic [7:0]  VEC_SYSCALL_BASE = 8'h20;

    // opcode patterns
    localparam logic [15:0] OP_RSV_A      = 16'h4AFA;
    localparam logic [15:0] OP_RSV_B      = 16'h4AFB;
    localparam logic [15:0] OP_RSV_C      = 16'h4AFC;
    localparam logic [3:0]  LINE_A_PAT    = 4'hA;
    localparam logic [3:0]  LINE_F_PAT    = 4'hF;
    localparam logic [11:0] SYSCALL_HI    = 12'h4E4;
    localparam logic [3:0]  SYSCALL_SUB   = 4'h4;

    localparam logic [31:0] PC_STEP       = 32'h0000_0002;

    typedef enum logic [2:0] {
        CIU_RUN,
        CIU_ACK,
        CIU_PUSH_PC,
        CIU_PUSH_SR,
        CIU_FETCH
    } ciu_state_t;

endpackage : ciu_pkg

// ### tb/ciu_irq_partner.sv
/*
 * far-side model: interrupt requester and acknowledge responder.
 * assumes the bench sets level, answer kind and delay between uses.
 */
`timescale 1ns/1ns
module ciu_irq_partner (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // bench control
    input  wire logic [2:0] i_level,
    input  wire logic [1:0] i_mode,
    input  wire logic [3:0] i_delay,
    input  wire logic [7:0] i_vec,
    // from the unit
    input  wire logic       i_ack_cycle,
    // to the unit
    output logic [2:0]      o_priority_request_lines_n,
    output logic            o_transfer_ack_n,
    output logic            o_autovector_request_n,
    output logic            o_bus_fault_n,
    output logic [7:0]      o_ack_data
);
    logic [3:0] wait_q;

    // ==========
    // request lines; level 0 reads as all lines negated
    assign o_priority_request_lines_n = ~i_level;

    // ==========
    // answer after i_delay cycles, held until the unit ends the cycle
    always @(negedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_q                 <= 4'h0;
            o_transfer_ack_n       <= 1'h1;
            o_autovector_request_n <= 1'h1;
            o_bus_fault_n          <= 1'h1;
            o_ack_data             <= 8'h00;
        end else if (i_ack_cycle && wait_q == i_delay) begin
            o_transfer_ack_n       <= ^i_mode;
            o_autovector_request_n <= i_mode != 2'h1;
            o_bus_fault_n          <= i_mode != 2'h2;
            o_ack_data             <= (i_mode == 2'h3) ? 8'h0F : i_vec;
        end else begin
            // released bus toggles each cycle, so a stale vector returns only every other cycle
            wait_q                 <= i_ack_cycle ? wait_q + 4'h1 : 4'h0;
            o_transfer_ack_n       <= 1'h1;
            o_autovector_request_n <= 1'h1;
            o_bus_fault_n          <= 1'h1;
            o_ack_data             <= ~o_ack_data;
        end
    end
endmodule : ciu_irq_partner

// ### tb/tb.sv
/*
 * self-checking bench for the exception unit.
 * assumes stack writes and vector fetch finish in at most two cycles each.
 */
`timescale 1ns/1ns
module tb
    import ciu_pkg::*;
;
    logic        clk, rst_b, boundary, legal, priv, ovf, bnd, dz, mem_done;
    logic        tack_n, avec_n, fault_n, busy, ack_cycle, push_pc, push_sr;
    logic        vfetch, short_frame, sf;
    logic [1:0]  mode;
    logic [2:0]  level, lines_n, ack_level;
    logic [3:0]  delay;
    logic [7:0]  vec, ack_data, vector;
    logic [15:0] opcode, status, stack_sr, o_stat;
    logic [31:0] next_pc, stack_pc;
    int          failures, checks_done;

    ciu_exception_unit DUT (.i_clk(clk), .i_rst_b(rst_b),
        .i_priority_request_lines_n(lines_n), .i_boundary(boundary),
        .i_opcode(opcode), .i_opcode_legal(legal),
        .i_opcode_privileged(priv), .i_overflow_check_fail(ovf),
        .i_bound_check_fail(bnd), .i_divide_by_zero(dz),
        .i_next_pc(next_pc), .i_status(status), .i_transfer_ack_n(tack_n),
        .i_autovector_request_n(avec_n), .i_bus_fault_n(fault_n),
        .i_ack_data(ack_data), .i_mem_done(mem_done), .o_busy(busy),
        .o_ack_cycle(ack_cycle), .o_ack_level(ack_level),
        .o_push_pc(push_pc), .o_push_sr(push_sr), .o_stack_pc(stack_pc),
        .o_stack_sr(stack_sr), .o_vector_fetch(vfetch), .o_vector(vector),
        .o_short_frame(short_frame), .o_status(o_stat));

    ciu_irq_partner u_partner (.i_clk(clk), .i_rst_b(rst_b),
        .i_level(level), .i_mode(mode), .i_delay(delay), .i_vec(vec),
        .i_ack_cycle(ack_cycle), .o_priority_request_lines_n(lines_n),
        .o_transfer_ack_n(tack_n), .o_autovector_request_n(avec_n),
        .o_bus_fault_n(fault_n), .o_ack_data(ack_data));

    // ==========
    // clock and memory side: done pulses every other cycle while a stack write or fetch is pending
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        mem_done <= (push_pc | push_sr | vfetch) & ~mem_done;
    end

    // ==========
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // status word with trace set, so clearing it is visible
    function automatic logic [15:0] sw(input logic [2:0] m, input logic s);
        return {1'h1, 1'h0, s, 2'h0, m, 8'h00};
    endfunction : sw

    task automatic set_level(input logic [2:0] l);
        level = l;
        repeat (4) @(negedge clk);
    endtask : set_level

    task automatic step(input logic [15:0] op, input logic [4:0] fl,
                        input logic [15:0] st);
        @(negedge clk);
        {legal, priv, ovf, bnd, dz} = fl;
        opcode = op;
        status = st;
        next_pc = next_pc + 32'h0000_0010;
        boundary = 1'h1;
        @(negedge clk);
        boundary = 1'h0;
        {legal, priv, ovf, bnd, dz} = 5'h10;
    endtask : step

    task automatic idle();
        repeat (3) @(negedge clk);
        check(busy, 1'h0);
    endtask : idle

    task automatic take(input logic [7:0] ev, input logic [2:0] lv,
                        input logic [15:0] st);
        int         n;
        logic [2:0] got;
        logic [1:0] stacked;
        n = 0;
        got = 3'h0;
        stacked = 2'h0;
        while (vfetch !== 1'h1 && n < 40) begin
            if (ack_cycle === 1'h1) begin
                got = ack_level;
            end
            // counter word must be pushed before the status copy
            stacked[0] = stacked[0] | (push_pc === 1'h1);
            stacked[1] = stacked[1] | (push_sr === 1'h1 && stacked[0]);
            @(negedge clk);
            n++;
        end
        sf = short_frame;
        check(vfetch, 1'h1);
        check(stacked, 2'h3);
        check(short_frame, 1'h1);
        check(vector, ev);
        check(got, lv);
        check(stack_pc, next_pc);
        check(stack_sr, st);
        check(o_stat, {1'h0, st[14], 1'h1, st[12:11],
              (lv == 3'h0) ? st[10:8] : lv, st[7:0]});
        while (busy !== 1'h0 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check(busy, 1'h0);
    endtask : take

    // ==========
    // scenarios
    task automatic t_defer();
        set_level(3'h3);
        check(busy, 1'h0);
        step(16'h4E71, 5'h10, sw(3'h3, 1'h1));
        idle();
        step(16'h4E71, 5'h10, sw(3'h2, 1'h0));
        take(8'h1B, 3'h3, sw(3'h2, 1'h0));
    endtask : t_defer

    task automatic t_respond();
        logic [7:0] ev [4];
        ev = '{8'h40, 8'h1D, VEC_SPURIOUS, 8'h0F};
        set_level(3'h5);
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            delay = 4'(m * 3);
            step(16'h4E71, 5'h10, sw(3'h4, 1'h1));
            take(ev[m], 3'h5, sw(3'h4, 1'h1));
            if (m == 2) begin
                check(sf, 1'h1);
            end
        end
    endtask : t_respond

    task automatic t_level7();
        mode = 2'h1;
        delay = 4'h0;
        set_level(3'h7);
        step(16'h4E71, 5'h10, sw(3'h7, 1'h1));
        take(8'h1F, 3'h7, sw(3'h7, 1'h1));
        step(16'h4E71, 5'h10, sw(3'h7, 1'h1));
        idle();
        step(16'h4E71, 5'h10, sw(3'h3, 1'h1));
        take(8'h1F, 3'h7, sw(3'h3, 1'h1));
        set_level(3'h0);
    endtask : t_level7

    task automatic trap(input logic [15:0] op, input logic [4:0] fl,
                        input logic s, input logic [7:0] ev);
        step(op, fl, sw(3'h0, s));
        take(ev, 3'h0, sw(3'h0, s));
    endtask : trap

    task automatic t_traps();
        trap(16'h4E45, 5'h10, 1'h0, 8'h25);
        trap(16'h4E4F, 5'h10, 1'h1, 8'h2F);
        trap(16'h4E76, 5'h14, 1'h0, VEC_OVERFLOW);
        trap(16'h4180, 5'h12, 1'h0, VEC_BOUND);
        trap(16'h81C1, 5'h11, 1'h1, VEC_ZERO_DIV);
        trap(16'h0FFF, 5'h00, 1'h0, VEC_ILLEGAL);
        trap(16'h4AFA, 5'h10, 1'h1, VEC_ILLEGAL);
        trap(16'h4AFB, 5'h10, 1'h1, VEC_ILLEGAL);
        trap(16'h4AFC, 5'h10, 1'h0, VEC_ILLEGAL);
        trap(16'hA123, 5'h00, 1'h0, VEC_LINE_A);
        trap(16'hF123, 5'h00, 1'h1, VEC_LINE_F);
        trap(16'h4E72, 5'h18, 1'h0, VEC_PRIV);
        step(16'h4E72, 5'h18, sw(3'h0, 1'h1));
        idle();
    endtask : t_traps

    // ==========
    // main sequence and watchdog
    initial begin
        {rst_b, boundary, failures, checks_done} = '0;
        {legal, priv, ovf, bnd, dz} = 5'h10;
        {opcode, status, next_pc} = {16'h4E71, sw(3'h0, 1'h1), 32'h1000};
        {level, mode, delay, vec} = {3'h0, 2'h1, 4'h0, 8'h40};
        repeat (6) @(negedge clk);
        rst_b = 1'h1;
        repeat (3) @(negedge clk);
        t_defer();
        t_respond();
        t_level7();
        t_traps();
        complete_run();
    end

    initial begin
        #50000;
        failures++;
        complete_run();
    end
endmodule : tb
